// >>> pkg/cfg_sideband_pkg.sv
// Package: constants, register map and state types of the configuration
// side-band and completion error report block.
// Assumes a 32-bit plain register port with word-aligned byte offsets.
package cfg_sideband_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int TC_NUM = 8;
    localparam int VC_W = 3;
    localparam int MAP_W = TC_NUM * VC_W;
    localparam int BUSDEV_W = 13;
    localparam int BUS_LSB = 5;
    localparam int ERR_W = 3;
    localparam int IRQ_W = 4;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_TCVC_MAP = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_BUSDEV = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_PRIM_CSR = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_DEV_CSR = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_LINK_CSR = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_PM_STATUS = 8'h20;

    // Completion error bit positions
    localparam int ERR_CTO = 0;
    localparam int ERR_CA = 1;
    localparam int ERR_UNEXP = 2;

    // Interrupt status bit positions
    localparam int IRQ_CTO = 0;
    localparam int IRQ_CA = 1;
    localparam int IRQ_UNEXP = 2;
    localparam int IRQ_LP_ENTER = 3;

    // Reset values
    localparam logic [MAP_W-1:0] RST_TCVC_MAP = 24'h00_0000;
    localparam logic [BUSDEV_W-1:0] RST_BUSDEV = 13'h0000;
    localparam logic [DATA_W-1:0] RST_CSR = 32'h0000_0000;
    localparam logic [IRQ_W-1:0] RST_IRQ = 4'h0;
    localparam logic [VC_W-1:0] VC_ZERO = 3'h0;

    typedef enum logic [1:0] {
        PM_ACTIVE,
        PM_WAIT_CPL,
        PM_LOW_POWER
    } pm_state_t;
endpackage

// >>> hw/cfg_sideband_cpl_error_report.sv
// Configuration side-band export and completion error report logic.
// Assumes application inputs are on clk_i; message engine acknowledges
// each pending error message with a one-cycle ack pulse.
`timescale 1ns/1ps
`default_nettype none

module cfg_sideband_cpl_error_report (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Register port
    input wire logic [cfg_sideband_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [cfg_sideband_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [cfg_sideband_pkg::DATA_W-1:0] reg_rdata_o,
    // Side-band configuration outputs
    output logic [cfg_sideband_pkg::MAP_W-1:0] cfg_tcvc_map_o,
    output logic [cfg_sideband_pkg::BUSDEV_W-1:0] cfg_busdev_o,
    output logic [cfg_sideband_pkg::DATA_W-1:0] cfg_prim_csr_o,
    output logic [cfg_sideband_pkg::DATA_W-1:0] cfg_dev_csr_o,
    output logic [cfg_sideband_pkg::DATA_W-1:0] cfg_link_csr_o,
    // Completion error reports from the application
    input wire logic [cfg_sideband_pkg::ERR_W-1:0] cpl_err_i,
    input wire logic cpl_pending_i,
    // Error message requests toward the transmit side
    output logic cto_msg_req_o,
    output logic ca_msg_req_o,
    input wire logic cto_msg_ack_i,
    input wire logic ca_msg_ack_i,
    // Low-power entry handshake
    input wire logic lp_req_i,
    output logic lp_enter_o,
    // Interrupt
    output logic irq_o
);
    import cfg_sideband_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Register map (byte offsets, one 32-bit word each)
    //
    // 0x00  Class-to-channel map in bits 23:0, class 0 field reads zero
    // 0x04  Bus number in 12:5, device number in 4:0
    // 0x08  Primary command/status
    // 0x0C  Device control/status
    // 0x10  Link control/status
    // 0x14  Event status, read only
    // 0x18  Event enable
    // 0x1C  Event clear, write ones, reads zero
    // 0x20  Power status: 0 granted, 1 waiting, 2 pending input
    //
    // Event bits: 0 timeout, 1 abort, 2 unexpected completion,
    // 3 low-power granted.
    // Unmapped reads return zero and unmapped writes do nothing, so
    // software probing the space sees no side effects.
    //
    // Timing: writes land on the strobe edge; read data stand for the one
    // cycle after the read strobe and are zero otherwise; message requests
    // rise the cycle after an error edge and fall the cycle after their ack;
    // the grant rises the cycle after a request sees no pending completion.
    //
    // Limits: error edges that arrive while a request still stands merge
    // into it, so software only sees the sticky status bit for them.
    // The unexpected completion bit raises no message, only status.

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [MAP_W-1:0] tcvc_map;
        logic [BUSDEV_W-1:0] busdev;
        logic [DATA_W-1:0] prim_csr;
        logic [DATA_W-1:0] dev_csr;
        logic [DATA_W-1:0] link_csr;
        logic [ERR_W-1:0] err_prev;
        logic cto_pend;
        logic ca_pend;
        pm_state_t pm_state;
        logic lp_enter;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_enable;
        logic irq;
        logic [DATA_W-1:0] rdata;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    // Everything clears to zero: the function looks idle and unconfigured
    // until software loads the registers.
    localparam state_t ST_RESET = '{
        tcvc_map: RST_TCVC_MAP,
        busdev: RST_BUSDEV,
        prim_csr: RST_CSR,
        dev_csr: RST_CSR,
        link_csr: RST_CSR,
        err_prev: 3'h0,
        cto_pend: 1'b0,
        ca_pend: 1'b0,
        pm_state: PM_ACTIVE,
        lp_enter: 1'b0,
        irq_status: RST_IRQ,
        irq_enable: RST_IRQ,
        irq: 1'b0,
        rdata: RST_CSR
    };

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Class 0 field is never storable, whatever software writes
    function automatic logic [MAP_W-1:0] clean_map(input logic [MAP_W-1:0] map);
        logic [MAP_W-1:0] m;
        m = map;
        m[VC_W-1:0] = VC_ZERO;
        return m;
    endfunction

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        return a == off;
    endfunction

    // Power status word; the live pending input is shown so software
    // can see why a grant is late
    function automatic logic [DATA_W-1:0] pm_word(input pm_state_t s, input logic lp, input logic pend);
        logic [DATA_W-1:0] w;
        w = '0;
        w[0] = lp;
        w[1] = (s == PM_WAIT_CPL);
        w[2] = pend;
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state

    logic [ERR_W-1:0] err_rise;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;
    logic lp_granted;

    always_comb begin
        st_nxt = st_r;
        irq_clr = '0;

        // One event per assertion, level length does not matter
        err_rise = cpl_err_i & ~st_r.err_prev;
        st_nxt.err_prev = cpl_err_i;

        // Register writes
        if (reg_wr_i) begin
            if (addr_hit(reg_addr_i, OFF_TCVC_MAP)) begin
                st_nxt.tcvc_map = clean_map(reg_wdata_i[MAP_W-1:0]);
            end else if (addr_hit(reg_addr_i, OFF_BUSDEV)) begin
                st_nxt.busdev = reg_wdata_i[BUSDEV_W-1:0];
            end else if (addr_hit(reg_addr_i, OFF_PRIM_CSR)) begin
                st_nxt.prim_csr = reg_wdata_i;
            end else if (addr_hit(reg_addr_i, OFF_DEV_CSR)) begin
                st_nxt.dev_csr = reg_wdata_i;
            end else if (addr_hit(reg_addr_i, OFF_LINK_CSR)) begin
                st_nxt.link_csr = reg_wdata_i;
            end else if (addr_hit(reg_addr_i, OFF_IRQ_ENABLE)) begin
                st_nxt.irq_enable = reg_wdata_i[IRQ_W-1:0];
            end else if (addr_hit(reg_addr_i, OFF_IRQ_CLEAR)) begin
                irq_clr = reg_wdata_i[IRQ_W-1:0];
            end
        end

        // Message requests stay up until acked; a new edge in the ack
        // cycle keeps the request so no event is dropped.
        // The transmit side may take as long as it likes to ack: the
        // request simply stands, and further edges in that time fold
        // into the one message, trading exact counts for no buffering.
        // Ack with no request standing is harmless.
        if (cto_msg_ack_i) begin
            st_nxt.cto_pend = 1'b0;
        end
        if (err_rise[ERR_CTO]) begin
            st_nxt.cto_pend = 1'b1;
        end
        if (ca_msg_ack_i) begin
            st_nxt.ca_pend = 1'b0;
        end
        if (err_rise[ERR_CA]) begin
            st_nxt.ca_pend = 1'b1;
        end

        // Low-power gate.
        // A request seen with completions pending parks in the wait state
        // instead of being refused, so the requester need only hold its
        // level. Dropping the request anywhere returns to active, which
        // also cancels a wait. The grant is a level, not a pulse, so the
        // power logic can hold its state off it directly.
        lp_granted = 1'b0;
        case (st_r.pm_state)
            PM_ACTIVE: begin
                if (lp_req_i) begin
                    if (cpl_pending_i) begin
                        st_nxt.pm_state = PM_WAIT_CPL;
                    end else begin
                        st_nxt.pm_state = PM_LOW_POWER;
                        lp_granted = 1'b1;
                    end
                end
            end
            PM_WAIT_CPL: begin
                if (!lp_req_i) begin
                    st_nxt.pm_state = PM_ACTIVE;
                end else if (!cpl_pending_i) begin
                    st_nxt.pm_state = PM_LOW_POWER;
                    lp_granted = 1'b1;
                end
            end
            PM_LOW_POWER: begin
                if (!lp_req_i) begin
                    st_nxt.pm_state = PM_ACTIVE;
                end
            end
            default: begin
                st_nxt.pm_state = PM_ACTIVE;
            end
        endcase
        st_nxt.lp_enter = (st_nxt.pm_state == PM_LOW_POWER);

        // Sticky status, set beats clear in the same cycle.
        // Losing an event to a racing clear would hide it from software
        // for good; a spurious extra bit only costs one more clear.
        // The interrupt uses next-state values so it tracks status exactly.
        irq_set = {lp_granted, err_rise};
        st_nxt.irq_status = (st_r.irq_status & ~irq_clr) | irq_set;
        st_nxt.irq = |(st_nxt.irq_status & st_nxt.irq_enable);

        // Read data valid only in the cycle after the strobe
        st_nxt.rdata = '0;
        if (reg_rd_i) begin
            if (addr_hit(reg_addr_i, OFF_TCVC_MAP)) begin
                st_nxt.rdata = {{(DATA_W-MAP_W){1'b0}}, st_r.tcvc_map};
            end else if (addr_hit(reg_addr_i, OFF_BUSDEV)) begin
                st_nxt.rdata = {{(DATA_W-BUSDEV_W){1'b0}}, st_r.busdev};
            end else if (addr_hit(reg_addr_i, OFF_PRIM_CSR)) begin
                st_nxt.rdata = st_r.prim_csr;
            end else if (addr_hit(reg_addr_i, OFF_DEV_CSR)) begin
                st_nxt.rdata = st_r.dev_csr;
            end else if (addr_hit(reg_addr_i, OFF_LINK_CSR)) begin
                st_nxt.rdata = st_r.link_csr;
            end else if (addr_hit(reg_addr_i, OFF_IRQ_STATUS)) begin
                st_nxt.rdata = {{(DATA_W-IRQ_W){1'b0}}, st_r.irq_status};
            end else if (addr_hit(reg_addr_i, OFF_IRQ_ENABLE)) begin
                st_nxt.rdata = {{(DATA_W-IRQ_W){1'b0}}, st_r.irq_enable};
            end else if (addr_hit(reg_addr_i, OFF_PM_STATUS)) begin
                st_nxt.rdata = pm_word(st_r.pm_state, st_r.lp_enter, cpl_pending_i);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    // Reset loads constants only; an error level already high at release
    // counts as one event, because the previous-level copy clears to zero.

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_r <= ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flops
    // No logic sits between state and pins, so the application sees
    // glitch-free levels with a full cycle of settling time.

    assign cfg_tcvc_map_o = st_r.tcvc_map;
    assign cfg_busdev_o = st_r.busdev;
    assign cfg_prim_csr_o = st_r.prim_csr;
    assign cfg_dev_csr_o = st_r.dev_csr;
    assign cfg_link_csr_o = st_r.link_csr;
    assign cto_msg_req_o = st_r.cto_pend;
    assign ca_msg_req_o = st_r.ca_pend;
    assign lp_enter_o = st_r.lp_enter;
    assign irq_o = st_r.irq;
    assign reg_rdata_o = st_r.rdata;

endmodule

`default_nettype wire

// >>> test/cfg_sideband_asserts.sv
// Port-level checker for the side-band and completion error block.
// Assumes one clock domain with an active-high async reset.
`timescale 1ns/1ps
`default_nettype none
module cfg_sideband_asserts
    import cfg_sideband_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [DATA_W-1:0] reg_rdata_o,
    input wire logic [MAP_W-1:0] cfg_tcvc_map_o,
    input wire logic [ERR_W-1:0] cpl_err_i,
    input wire logic cpl_pending_i,
    input wire logic cto_msg_req_o,
    input wire logic ca_msg_req_o,
    input wire logic cto_msg_ack_i,
    input wire logic lp_req_i,
    input wire logic lp_enter_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    a_map_tc_zero: assert property (cfg_tcvc_map_o[2:0] == VC_ZERO)
        else $error("class 0 field of map not zero");
    a_map_field_write: assert property (reg_wr_i && reg_addr_i == OFF_TCVC_MAP |=>
        cfg_tcvc_map_o[23:3] == $past(reg_wdata_i[23:3])) else $error("map fields not as written");
    a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
        else $error("read data outside read answer");
    a_cto_event_req: assert property ($rose(cpl_err_i[ERR_CTO]) |=> cto_msg_req_o)
        else $error("timeout message not requested");
    a_ca_event_req: assert property ($rose(cpl_err_i[ERR_CA]) |=> ca_msg_req_o)
        else $error("abort message not requested");
    a_cto_req_ack: assert property (cto_msg_req_o && !$rose(cpl_err_i[ERR_CTO]) |=>
        cto_msg_req_o == !$past(cto_msg_ack_i)) else $error("timeout request not held until ack");
    a_lp_hold_off: assert property ($rose(lp_enter_o) |->
        !$past(cpl_pending_i) && $past(lp_req_i)) else $error("low power entered while pending");
    a_lp_grant_pending: assert property (lp_req_i && !cpl_pending_i |=> lp_enter_o)
        else $error("low power not granted after pending dropped");
endmodule
`default_nettype wire

// >>> test/msg_ack_model.sv
// Application-side acknowledge for one error message request line.
// Assumes the request stays high until acknowledged; DLY sets the latency.
`timescale 1ns/1ps
`default_nettype none
module msg_ack_model #(
    parameter int DLY = 0
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic req_i,
    output logic ack_o
);
    int cnt;
    // Skip the cycle after an ack: the request only falls one edge later
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt <= 0;
            ack_o <= 1'b0;
        end else begin
            ack_o <= 1'b0;
            if (req_i && !ack_o) begin
                ack_o <= (cnt == DLY);
                cnt <= (cnt == DLY) ? 0 : cnt + 1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> test/tb.sv
// Bench for the side-band block: config export, error events, low power.
// Assumes two ack models stand in for the application message side.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fails++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb;
    import cfg_sideband_pkg::*;
    logic clk_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, cpl_pending_i = 0, lp_req_i = 0;
    logic [ADDR_W-1:0] reg_addr_i = '0;
    logic [DATA_W-1:0] reg_wdata_i = '0, reg_rdata_o, cfg_prim_csr_o, cfg_dev_csr_o, cfg_link_csr_o, d;
    logic [DATA_W-1:0] outs [5];
    logic [MAP_W-1:0] cfg_tcvc_map_o;
    logic [BUSDEV_W-1:0] cfg_busdev_o;
    logic [ERR_W-1:0] cpl_err_i = '0;
    logic cto_msg_req_o, ca_msg_req_o, cto_msg_ack_i, ca_msg_ack_i, lp_enter_o, irq_o;
    int fails = 0, comparisons = 0, cyc = 0;
    cfg_sideband_cpl_error_report u_cfg_sideband_cpl_error_report (.*);
    msg_ack_model #(.DLY(0)) u_msg_ack_model (.clk_i, .sys_rst_i, .req_i(cto_msg_req_o), .ack_o(cto_msg_ack_i));
    // Slow abort ack keeps that request standing for several cycles
    msg_ack_model #(.DLY(3)) u_msg_ack_model_ca (.clk_i, .sys_rst_i, .req_i(ca_msg_req_o), .ack_o(ca_msg_ack_i));
    always_comb outs = '{32'(cfg_tcvc_map_o), 32'(cfg_busdev_o), cfg_prim_csr_o, cfg_dev_csr_o, cfg_link_csr_o};
    initial forever #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task test_done;
        if (fails == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 v = reg_rdata_o;
    endtask
    task t_cfg;
        logic [DATA_W-1:0] v, e;
        for (int i = 0; i < 5; i++) begin
            v = 32'h5A3C_96F7 + (i << 9);
            e = (i == 0) ? {8'h00, v[23:3], 3'h0} : (i == 1) ? {19'h0_0000, v[12:0]} : v;
            wr(8'(i * 4), v);
            rd(8'(i * 4), d);
            `CHK("cfg readback", e, d)
            `CHK("cfg output", e, outs[i])
        end
        `CHK("class 7 channel", 3'h1, cfg_tcvc_map_o[23:21])
        `CHK("requester id", 16'hC7B8, {cfg_busdev_o, 3'h0})
        rd(8'h24, d);
        `CHK("unmapped read", 32'h0000_0000, d)
    endtask
    task t_err;
        int n0, n1;
        logic p0, p1;
        n0 = 0;
        n1 = 0;
        p0 = 1'b0;
        p1 = 1'b0;
        wr(OFF_IRQ_ENABLE, 32'h0000_0000);
        @(posedge clk_i);
        cpl_err_i <= 3'h7;
        repeat (16) begin
            @(posedge clk_i);
            #1;
            n0 += cto_msg_req_o && !p0;
            n1 += ca_msg_req_o && !p1;
            p0 = cto_msg_req_o;
            p1 = ca_msg_req_o;
        end
        `CHK("timeout messages", 1, n0)
        `CHK("abort messages", 1, n1)
        `CHK("masked irq", 1'b0, irq_o)
        rd(OFF_IRQ_STATUS, d);
        `CHK("error status", 32'h0000_0007, d)
        wr(OFF_IRQ_ENABLE, 32'h0000_0007);
        @(posedge clk_i);
        #1 `CHK("irq raised", 1'b1, irq_o)
        // Level still high: clearing must stick, no fresh event
        wr(OFF_IRQ_CLEAR, 32'h0000_0007);
        rd(OFF_IRQ_STATUS, d);
        `CHK("held level cleared", 32'h0000_0000, d)
        `CHK("irq cleared", 1'b0, irq_o)
        @(posedge clk_i);
        cpl_err_i <= 3'h0;
    endtask
    task t_lp;
        @(posedge clk_i);
        cpl_pending_i <= 1'b1;
        lp_req_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        #1 `CHK("low power held off", 1'b0, lp_enter_o)
        rd(OFF_PM_STATUS, d);
        `CHK("waiting status", 32'h0000_0006, d)
        @(posedge clk_i);
        cpl_pending_i <= 1'b0;
        @(posedge clk_i);
        #1 `CHK("low power granted", 1'b1, lp_enter_o)
        rd(OFF_IRQ_STATUS, d);
        `CHK("low power status", 32'h0000_0008, d)
        rd(OFF_PM_STATUS, d);
        `CHK("granted status", 32'h0000_0001, d)
        @(posedge clk_i);
        lp_req_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1 `CHK("low power released", 1'b0, lp_enter_o)
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        #1 `CHK("reset map", 24'h00_0000, cfg_tcvc_map_o)
        t_cfg();
        t_err();
        t_lp();
        test_done();
    end
endmodule
bind cfg_sideband_cpl_error_report cfg_sideband_asserts u_cfg_sideband_asserts (.*);
`default_nettype wire
